//--- design/txcwd_pkg.sv
package txcwd_pkg;
   // command word a field positions
   localparam int unsigned A_SIZE_LSB = 0;
   localparam int unsigned A_SIZE_W = 11;
   localparam int unsigned A_LAST_SEG_BIT = 12;
   localparam int unsigned A_FIRST_SEG_BIT = 13;
   localparam int unsigned A_OFFSET_LSB = 16;
   localparam int unsigned A_OFFSET_W = 5;
   localparam int unsigned A_ALIGN_LSB = 24;
   localparam int unsigned A_ALIGN_W = 2;
   // command word b field positions
   localparam int unsigned B_LEN_LSB = 0;
   localparam int unsigned B_LEN_W = 11;
   localparam int unsigned B_PAD_DIS_BIT = 12;
   localparam int unsigned B_CRC_DIS_BIT = 13;
   localparam int unsigned B_CSUM_BIT = 14;
   localparam int unsigned B_TAG_LSB = 16;
   localparam int unsigned B_TAG_W = 16;
   // end alignment codes
   localparam logic [1:0] ALIGN_4 = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [1:0] ALIGN_RSVD = 2'h3;
   // alignment masks in bytes
   localparam logic [12:0] MASK_4 = 13'h0003;
   localparam logic [12:0] MASK_16 = 13'h000F;
   localparam logic [12:0] MASK_32 = 13'h001F;
   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INT_STS = 8'h04;
   localparam logic [7:0] REG_INT_MASK = 8'h08;
   localparam logic [7:0] REG_LAST_STS = 8'h0C;
   // register bit positions
   localparam int unsigned CTRL_CSUM_EN_BIT = 0;
   localparam int unsigned INT_ERR_BIT = 0;
   localparam int unsigned INT_DONE_BIT = 1;
   localparam int unsigned LAST_ERR_BIT = 15;
   localparam int unsigned INT_W = 2;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [INT_W-1:0] INT_RST = 2'h0;
   // decoder states, gray along cmd a, cmd b, data
   typedef enum logic [1:0] {
      S_CMDA = 2'h0,
      S_CMDB = 2'h1,
      S_DATA = 2'h3
   } txcwd_state_t;
endpackage

//--- design/txcwd_len_if.sv
`timescale 1ns/1ps
`default_nettype none
// buffer geometry between the decoder and its length calculator
interface txcwd_len_if;
   logic [4:0] offset; // data start offset in bytes
   logic [10:0] size; // buffer byte count
   logic [1:0] align; // end alignment code
   logic [2:0] skip_words; // whole dwords stripped ahead of data
   logic [10:0] total_words; // dwords the host writes after cmd b
   logic [10:0] last_word; // index of the last data dword
   logic empty; // buffer carries no data bytes
   logic [3:0] first_be; // lanes valid in the first data dword
   logic [3:0] last_be; // lanes valid in the last data dword
   logic align_bad; // reserved alignment code seen
   modport calc (input offset, size, align,
      output skip_words, total_words, last_word, empty, first_be, last_be, align_bad);
   modport user (output offset, size, align,
      input skip_words, total_words, last_word, empty, first_be, last_be, align_bad);
endinterface
`default_nettype wire

//--- design/txcwd_len_calc.sv
`timescale 1ns/1ps
`default_nettype none
// purely combinational buffer geometry
module txcwd_len_calc
   import txcwd_pkg::*;
(
   txcwd_len_if.calc lif
);
   logic [12:0] end_bytes; // offset plus size
   logic [12:0] last_byte; // index of last data byte
   logic [12:0] mask; // alignment mask
   logic [12:0] rounded; // end rounded up to alignment

   ////////////////////////////////////////////////////////////////////////
   // alignment decode and padding count
   always_comb begin
      end_bytes = 13'(lif.offset) + 13'(lif.size);
      last_byte = end_bytes - 13'h0001;
      lif.align_bad = 1'b0;
      unique case (lif.align)
         ALIGN_4: mask = MASK_4;
         ALIGN_16: mask = MASK_16;
         ALIGN_32: mask = MASK_32;
         ALIGN_RSVD: begin
            // reserved code: treated as 4-byte and flagged
            mask = MASK_4;
            lif.align_bad = 1'b1;
         end
      endcase
      rounded = (end_bytes + mask) & ~mask;
      lif.total_words = rounded[12:2];
      lif.last_word = last_byte[12:2];
      lif.skip_words = lif.offset[4:2];
      lif.empty = (lif.size == 11'h000);
      lif.first_be = 4'(4'hF << lif.offset[1:0]);
      lif.last_be = 4'(4'hF >> (2'h3 - last_byte[1:0]));
   end
endmodule // txcwd_len_calc
`default_nettype wire

//--- design/txcwd_decoder.sv
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - start offset from command a bits 20:16
// - command a bit 13 marks first segment
// - command a bit 12 marks last segment
// - buffer size plus alignment sets discarded padding
// - summed buffer sizes must equal packet length
// - command b tag goes into status word
// - checksum only with request, first segment, enable
// - command b bit 13 suppresses crc append
// - command b bit 12 disables short-frame padding
// - padding disabled forces crc append anyway
// - command b bits 10:0 are packet length
// - delivered byte count must equal packet length
// - command b identical across segments, else error
// - command a bits 25:24 give end alignment
module txcwd_decoder
   import txcwd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   // word stream from the transmit data fifo
   input wire logic in_valid,
   input wire logic [31:0] in_data,
   output logic in_ready,
   // data dwords toward the mac
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data,
   output logic [3:0] out_be,
   output logic out_first,
   output logic out_last,
   // per-packet controls
   output logic l3_checksum_request,
   output logic crc_append,
   output logic pad_enable,
   // status word toward the status fifo
   output logic status_valid,
   output logic [15:0] status_tag,
   output logic status_err,
   // error flag and interrupt
   output logic transmit_error_flag,
   output logic irq,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   ////////////////////////////////////////////////////////////////////////
   // declarations
   txcwd_state_t state_r, state_nxt; // parser state
   logic [31:0] cmda_r, cmda_nxt; // current command a
   logic [31:0] ref_r, ref_nxt; // command b of the open packet
   logic [11:0] sum_r, sum_nxt; // running buffer size sum
   logic [11:0] bytes_r, bytes_nxt; // bytes really delivered
   logic [10:0] wcnt_r, wcnt_nxt; // dword index within buffer
   logic err_r, err_nxt; // packet error so far
   logic open_r, open_nxt; // a packet is in progress
   logic first_pend_r, first_pend_nxt; // next emitted word opens packet
   logic out_valid_r, out_valid_nxt;
   logic [31:0] out_data_r, out_data_nxt;
   logic [3:0] out_be_r, out_be_nxt;
   logic out_first_r, out_first_nxt;
   logic out_last_r, out_last_nxt;
   logic l3_r, l3_nxt;
   logic crc_r, crc_nxt;
   logic pad_r, pad_nxt;
   logic st_valid_r, st_valid_nxt;
   logic [15:0] st_tag_r, st_tag_nxt;
   logic st_err_r, st_err_nxt;
   logic [31:0] ctrl_r, ctrl_nxt; // control register
   logic [INT_W-1:0] sts_r, sts_nxt; // sticky interrupt status
   logic [INT_W-1:0] mask_r, mask_nxt; // interrupt mask
   logic [31:0] rdata_r, rdata_nxt; // read data, one cycle late
   logic [INT_W-1:0] events; // this cycle's interrupt events
   logic take; // a word is accepted this cycle
   logic emit; // current data word carries payload
   logic buf_end; // current buffer completes this cycle
   logic seg_first; // first-segment marker of current buffer
   logic seg_last; // last-segment marker of current buffer
   logic [3:0] be; // lanes of the current data word
   logic [10:0] pkt_len; // packet length of the packet at hand

   txcwd_len_if lif();

   // number of valid lanes in a byte enable
   function automatic logic [2:0] lane_count(input logic [3:0] lanes);
      lane_count = 3'(lanes[0]) + 3'(lanes[1]) + 3'(lanes[2]) + 3'(lanes[3]);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // geometry of the current buffer, from the stored command a
   assign lif.offset = cmda_r[A_OFFSET_LSB +: A_OFFSET_W];
   assign lif.size = cmda_r[A_SIZE_LSB +: A_SIZE_W];
   assign lif.align = cmda_r[A_ALIGN_LSB +: A_ALIGN_W];

   txcwd_len_calc u_len (
      .lif(lif)
   );

   assign seg_first = cmda_r[A_FIRST_SEG_BIT];
   assign seg_last = cmda_r[A_LAST_SEG_BIT];

   ////////////////////////////////////////////////////////////////////////
   // payload window and lanes of the word at the fifo head
   always_comb begin
      emit = (state_r == S_DATA) && !lif.empty
         && (wcnt_r >= 11'(lif.skip_words)) && (wcnt_r <= lif.last_word);
      be = 4'hF;
      // start offset and end trim both apply to a one-dword buffer
      if (wcnt_r == 11'(lif.skip_words)) begin
         be = be & lif.first_be;
      end
      if (wcnt_r == lif.last_word) begin
         be = be & lif.last_be;
      end
   end

   // padding and stripped words are always taken; payload waits for the mac
   assign in_ready = emit ? (!out_valid_r || out_ready) : 1'b1;
   assign take = in_valid && in_ready;

   ////////////////////////////////////////////////////////////////////////
   // parser next-state
   always_comb begin
      state_nxt = state_r;
      cmda_nxt = cmda_r;
      ref_nxt = ref_r;
      sum_nxt = sum_r;
      bytes_nxt = bytes_r;
      wcnt_nxt = wcnt_r;
      err_nxt = err_r;
      open_nxt = open_r;
      first_pend_nxt = first_pend_r;
      out_valid_nxt = out_valid_r && !out_ready;
      out_data_nxt = out_data_r;
      out_be_nxt = out_be_r;
      out_first_nxt = out_first_r;
      out_last_nxt = out_last_r;
      l3_nxt = l3_r;
      crc_nxt = crc_r;
      pad_nxt = pad_r;
      st_valid_nxt = 1'b0;
      st_tag_nxt = st_tag_r;
      st_err_nxt = st_err_r;
      buf_end = 1'b0;
      unique case (state_r)
         S_CMDA: begin
            // first word of each buffer is command a
            if (take) begin
               cmda_nxt = in_data;
               state_nxt = S_CMDB;
            end
         end
         S_CMDB: begin
            if (take) begin
               if (seg_first) begin
                  // new packet: its command b is the reference
                  ref_nxt = in_data;
                  sum_nxt = 12'(lif.size);
                  bytes_nxt = 12'h000;
                  first_pend_nxt = 1'b1;
                  // a first segment while a packet is open is an error
                  err_nxt = open_r || lif.align_bad;
                  l3_nxt = in_data[B_CSUM_BIT] && ctrl_r[CTRL_CSUM_EN_BIT];
                  // padding off forces the crc on
                  crc_nxt = !in_data[B_CRC_DIS_BIT] || in_data[B_PAD_DIS_BIT];
                  pad_nxt = !in_data[B_PAD_DIS_BIT];
               end else begin
                  err_nxt = err_r || !open_r || lif.align_bad
                     || (in_data != ref_r);
                  sum_nxt = sum_r + 12'(lif.size);
               end
               open_nxt = 1'b1;
               wcnt_nxt = 11'h000;
               // zero offset and zero size: no data words follow
               if (lif.total_words == 11'h000) begin
                  buf_end = 1'b1;
               end else begin
                  state_nxt = S_DATA;
               end
            end
         end
         S_DATA: begin
            if (take) begin
               if (emit) begin
                  out_valid_nxt = 1'b1;
                  out_data_nxt = in_data;
                  out_be_nxt = be;
                  out_first_nxt = first_pend_r;
                  out_last_nxt = seg_last && (wcnt_r == lif.last_word);
                  first_pend_nxt = 1'b0;
                  bytes_nxt = bytes_r + 12'(lane_count(be));
               end
               // alignment padding words are dropped here
               wcnt_nxt = wcnt_r + 11'h001;
               if (wcnt_r == lif.total_words - 11'h001) begin
                  buf_end = 1'b1;
               end
            end
         end
         default: begin
            state_nxt = S_CMDA;
         end
      endcase
      // closing segment: check lengths and report status
      if (buf_end) begin
         state_nxt = S_CMDA;
         if (seg_last) begin
            st_valid_nxt = 1'b1;
            st_tag_nxt = ref_nxt[B_TAG_LSB +: B_TAG_W];
            st_err_nxt = err_nxt || (sum_nxt != 12'(pkt_len))
               || (bytes_nxt != 12'(pkt_len));
            open_nxt = 1'b0;
         end
      end
   end

   // length of the packet, from the command b now in force
   assign pkt_len = ref_nxt[B_LEN_LSB +: B_LEN_W];

   ////////////////////////////////////////////////////////////////////////
   // parser registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= S_CMDA;
         cmda_r <= 32'h0000_0000;
         ref_r <= 32'h0000_0000;
         sum_r <= 12'h000;
         bytes_r <= 12'h000;
         wcnt_r <= 11'h000;
         err_r <= 1'b0;
         open_r <= 1'b0;
         first_pend_r <= 1'b0;
         out_valid_r <= 1'b0;
         out_data_r <= 32'h0000_0000;
         out_be_r <= 4'h0;
         out_first_r <= 1'b0;
         out_last_r <= 1'b0;
         l3_r <= 1'b0;
         crc_r <= 1'b1;
         pad_r <= 1'b1;
         st_valid_r <= 1'b0;
         st_tag_r <= 16'h0000;
         st_err_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmda_r <= cmda_nxt;
         ref_r <= ref_nxt;
         sum_r <= sum_nxt;
         bytes_r <= bytes_nxt;
         wcnt_r <= wcnt_nxt;
         err_r <= err_nxt;
         open_r <= open_nxt;
         first_pend_r <= first_pend_nxt;
         out_valid_r <= out_valid_nxt;
         out_data_r <= out_data_nxt;
         out_be_r <= out_be_nxt;
         out_first_r <= out_first_nxt;
         out_last_r <= out_last_nxt;
         l3_r <= l3_nxt;
         crc_r <= crc_nxt;
         pad_r <= pad_nxt;
         st_valid_r <= st_valid_nxt;
         st_tag_r <= st_tag_nxt;
         st_err_r <= st_err_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register file next-state
   always_comb begin
      events = '0;
      events[INT_ERR_BIT] = st_valid_r && st_err_r;
      events[INT_DONE_BIT] = st_valid_r;
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      sts_nxt = sts_r;
      rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            ctrl_nxt = {31'h0000_0000, reg_wdata[CTRL_CSUM_EN_BIT]};
         end
         if (reg_addr == REG_INT_MASK) begin
            mask_nxt = reg_wdata[INT_W-1:0];
         end
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: rdata_nxt = ctrl_r;
            REG_INT_STS: begin
               rdata_nxt = 32'(sts_r);
               // read clears
               sts_nxt = '0;
            end
            REG_INT_MASK: rdata_nxt = 32'(mask_r);
            REG_LAST_STS: begin
               rdata_nxt = {st_tag_r, 16'h0000};
               rdata_nxt[LAST_ERR_BIT] = st_err_r;
            end
            // unmapped reads return zero
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      // a set in the clearing cycle survives
      sts_nxt = sts_nxt | events;
   end

   ////////////////////////////////////////////////////////////////////////
   // register file registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         sts_r <= INT_RST;
         mask_r <= INT_RST;
         rdata_r <= 32'h0000_0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         sts_r <= sts_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
   assign out_be = out_be_r;
   assign out_first = out_first_r;
   assign out_last = out_last_r;
   assign l3_checksum_request = l3_r;
   assign crc_append = crc_r;
   assign pad_enable = pad_r;
   assign status_valid = st_valid_r;
   assign status_tag = st_tag_r;
   assign status_err = st_err_r;
   assign transmit_error_flag = sts_r[INT_ERR_BIT];
   assign irq = |(sts_r & mask_r);
   assign reg_rdata = rdata_r;
endmodule // txcwd_decoder
`default_nettype wire

//--- tb/txcwd_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher for the command word decoder
module txcwd_assertions
   import txcwd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [31:0] in_data,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [31:0] out_data,
   input wire logic [3:0] out_be,
   input wire logic out_first,
   input wire logic out_last,
   input wire logic l3_checksum_request,
   input wire logic crc_append,
   input wire logic pad_enable,
   input wire logic status_valid,
   input wire logic [15:0] status_tag,
   input wire logic status_err,
   input wire logic transmit_error_flag,
   input wire logic irq,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   ////////////////////////
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // a beat refused by the mac, then the same beat again
   sequence s_stall;
      out_valid && !out_ready;
   endsequence
   sequence s_held;
      out_valid && $stable(out_data) && $stable(out_be) && $stable(out_last);
   endsequence
   ////////////////////////
   chk_beat_hold: assert property (s_stall |=> s_held)
      else $error("payload beat moved while stalled");
   chk_first_lane: assert property (out_valid && out_first && !out_last |-> out_be[3])
      else $error("first beat lanes wrong");
   chk_crc_forced: assert property (!pad_enable |-> crc_append)
      else $error("crc dropped with padding off");
   chk_cksum_cause: assert property ($rose(l3_checksum_request)
      |-> $past(in_valid && in_ready && in_data[B_CSUM_BIT]))
      else $error("checksum request without its bit");
   chk_status_pulse: assert property (status_valid |=> !status_valid)
      else $error("status pulse too long");
   chk_tag_hold: assert property ($changed(status_tag) |-> status_valid)
      else $error("tag moved outside status");
   chk_err_sticky: assert property (status_valid && status_err |=> transmit_error_flag)
      else $error("error flag not raised");
   chk_err_cause: assert property ($rose(transmit_error_flag)
      |-> $past(status_valid && status_err))
      else $error("error flag without bad status");
   chk_irq_cause: assert property ($rose(irq) |-> $past(status_valid || reg_wr))
      else $error("irq rose without cause");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside its slot");
endmodule // txcwd_assertions

bind txcwd_decoder txcwd_assertions i_chk (
   .clk_sys, .rst_n, .in_valid, .in_data, .in_ready, .out_valid, .out_ready, .out_data,
   .out_be, .out_first, .out_last, .l3_checksum_request, .crc_append, .pad_enable,
   .status_valid, .status_tag, .status_err, .transmit_error_flag, .irq, .reg_wr, .reg_rd,
   .reg_rdata
);
`default_nettype wire

//--- tb/txcwd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host writing command words and buffer dwords into the fifo port
module txcwd_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_ready,
   output logic in_valid,
   output logic [31:0] in_data
);
   logic [31:0] word_q[$]; // words in host order
   logic slow = 1'b0; // idle cycle after each word
   logic take; // word taken at this edge
   initial {in_valid, in_data} = 33'h0;
   ////////////////////////
   // word held until taken; idle bus shows inverted data
   always @(posedge clk_sys) begin
      take = in_valid && in_ready;
      if (take) begin
         void'(word_q.pop_front());
      end
      if (!rst_n) begin
         in_valid <= 1'b0;
      end else if (word_q.size() > 0 && !(slow && take) && (take || !in_valid)) begin
         in_valid <= 1'b1;
         in_data <= word_q[0];
      end else if (take || !in_valid) begin
         in_valid <= 1'b0;
         in_data <= ~in_data;
      end
   end
endmodule // txcwd_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the transmit command word decoder
module tb_top
   import txcwd_pkg::*;
;
   logic clk_sys = 1'b0; // 100 MHz
   logic rst_n = 1'b0; // synchronous, active low
   logic out_ready = 1'b1; // mac acceptance
   logic stall = 1'b0; // mac hesitates every other cycle
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic in_valid, in_ready, out_valid, out_first, out_last, l3_checksum_request;
   logic crc_append, pad_enable, status_valid, status_err, transmit_error_flag, irq;
   logic [31:0] in_data, out_data, reg_rdata;
   logic [3:0] out_be;
   logic [15:0] status_tag;
   int error_cnt = 0;
   int comparisons = 0;
   int cycle_cnt = 0;
   logic [37:0] exp_q[$]; // beats: data, lanes, first, last
   logic [31:0] st_q[$]; // status: tag, error
   logic irq_mask = 1'b0; // mirror of the error mask bit
   logic [15:0] data_cnt = 16'h0000; // payload pattern per buffer

   always #5 clk_sys = ~clk_sys;

   txcwd_decoder i_dut (.clk_sys, .rst_n, .in_valid, .in_data, .in_ready, .out_valid,
      .out_ready, .out_data, .out_be, .out_first, .out_last, .l3_checksum_request,
      .crc_append, .pad_enable, .status_valid, .status_tag, .status_err,
      .transmit_error_flag, .irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   txcwd_host_model i_host (.clk_sys, .rst_n, .in_ready, .in_valid, .in_data);
   ////////////////////////
   task automatic miss(input logic [37:0] got, input logic [37:0] exp);
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) miss({6'h00, got}, {6'h00, exp});
   endtask
   task automatic cmp_beat(input logic [37:0] got, input logic [37:0] exp);
      comparisons++;
      if (got !== exp) miss(got, exp);
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) miss({37'h0, got}, {37'h0, exp});
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////
   // register port tasks
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      cmp_reg(reg_rdata, exp);
   endtask
   function automatic logic [31:0] cmd_b(input logic [15:0] tag, input logic csum_req,
         input logic crc_dis, input logic pad_dis, input logic [10:0] len);
      return {tag, 1'b0, csum_req, crc_dis, pad_dis, 1'b0, len};
   endfunction
   // queue one buffer and the beats it must produce
   task automatic send_buf(input logic [4:0] off, input logic [10:0] size,
         input logic [1:0] al, input logic first_seg, input logic last_seg,
         input logic [31:0] b);
      int o, lo, hi, words;
      logic [31:0] w;
      logic [3:0] be;
      data_cnt = data_cnt + 16'h0001;
      o = int'(off);
      lo = o / 4;
      hi = (o + int'(size) - 1) / 4;
      words = (al == ALIGN_16) ? 16 : (al == ALIGN_32) ? 32 : 4; // reserved acts as 4
      words = (o + int'(size) + words - 1) / words * words / 4;
      i_host.word_q.push_back({6'h00, al, 3'h0, off, 2'h0, first_seg, last_seg, 1'b0, size});
      i_host.word_q.push_back(b);
      for (int i = 0; i < words; i++) begin
         w = {data_cnt, 16'(i)};
         i_host.word_q.push_back(w);
         if (size != 11'h000 && i >= lo && i <= hi) begin
            be = 4'hF;
            if (i == lo) be = be & (4'hF << off[1:0]);
            if (i == hi) be = be & (4'hF >> (3 - ((o + int'(size) - 1) % 4)));
            exp_q.push_back({w, be, first_seg && i == lo, last_seg && i == hi});
         end
      end
   endtask
   // drain the packet, then check flags and registers
   task automatic finish_pkt(input logic [15:0] tag, input logic err);
      st_q.push_back({15'h0000, tag, err});
      for (int i = 0; i < 400 && st_q.size() + exp_q.size() > 0; i++) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      cmp_reg(32'(st_q.size() + exp_q.size()), 32'h0000_0000);
      cmp_flag(transmit_error_flag, err);
      cmp_flag(irq, err & irq_mask);
      reg_read(REG_INT_STS, {30'h0, 1'b1, err});
      reg_read(REG_LAST_STS, {tag, err, 15'h0000});
   endtask
   ////////////////////////
   // mac side monitor; outputs read before this edge's updates land
   always @(posedge clk_sys) begin
      if (rst_n && out_valid && out_ready) begin
         cmp_beat({out_data, out_be, out_first, out_last}, exp_q.size() > 0 ? exp_q.pop_front() : 38'h0);
      end
      if (rst_n && status_valid) begin
         cmp_reg({15'h0, status_tag, status_err}, st_q.size() > 0 ? st_q.pop_front() : 32'hFFFF_FFFF);
      end
      out_ready <= stall ? ~out_ready : 1'b1;
   end
   // hang guard, far above the several hundred cycles needed
   always @(posedge clk_sys) begin
      cycle_cnt++;
      if (cycle_cnt == 50000) begin
         error_cnt++;
         print_verdict();
      end
   end
   ////////////////////////
   initial begin
      logic [31:0] b;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      cmp_flag(crc_append, 1'b1);
      cmp_flag(pad_enable, 1'b1);
      reg_write(REG_INT_STS, 32'hFFFF_FFFF);
      // whole map reads zero, unmapped 0x10 included
      for (int a = 0; a < 5; a++) reg_read(8'(a * 4), 32'h0000_0000);
      $display("test reset done");
      // each alignment, offsets 0 and 31, stalls on odd runs
      for (int a = 0; a < 4; a++) begin
         for (int k = 0; k < 2; k++) begin
            stall = k[0];
            i_host.slow = k[0];
            b = cmd_b(16'(a * 2 + k), 1'b0, 1'b0, 1'b0, 11'(5 + a * 13));
            send_buf(k[0] ? 5'd31 : 5'd0, 11'(5 + a * 13), a[1:0], 1'b1, 1'b1, b);
            finish_pkt(16'(a * 2 + k), a == 3);
         end
      end
      $display("test alignment done");
      // three segments: good, bad length, odd middle command b
      for (int m = 0; m < 3; m++) begin
         b = cmd_b(16'hA5A0, 1'b0, 1'b0, 1'b0, (m == 1) ? 11'd18 : 11'd19);
         send_buf(5'd2, 11'd6, ALIGN_16, 1'b1, 1'b0, b);
         send_buf(5'd0, 11'd4, ALIGN_4, 1'b0, 1'b0, (m == 2) ? b ^ 32'h0000_0001 : b);
         send_buf(5'd3, 11'd9, ALIGN_32, 1'b0, 1'b1, b);
         finish_pkt(16'hA5A0, m != 0);
      end
      stall = 1'b0;
      i_host.slow = 1'b0;
      $display("test segments done");
      // crc, padding and checksum controls vs engine enable
      for (int f = 0; f < 8; f++) begin
         reg_write(REG_CTRL, {31'h0, f[2] | f[1]});
         reg_read(REG_CTRL, {31'h0, f[2] | f[1]});
         b = cmd_b(16'(f), f[2] | f[0], f[0], f[1], 11'd3);
         send_buf(5'd1, 11'd3, ALIGN_4, 1'b1, 1'b1, b);
         finish_pkt(16'(f), 1'b0);
         cmp_flag(crc_append, ~f[0] | f[1]);
         cmp_flag(pad_enable, ~f[1]);
         cmp_flag(l3_checksum_request, f[2] | (f[0] & f[1]));
      end
      $display("test controls done");
      // unmasked error raises irq, status read drops it
      irq_mask = 1'b1;
      reg_write(REG_INT_MASK, 32'h0000_0001);
      reg_read(REG_INT_MASK, 32'h0000_0001);
      for (int e = 0; e < 2; e++) begin
         b = cmd_b(16'hBEEF, 1'b0, 1'b0, 1'b0, e[0] ? 11'd9 : 11'd8);
         send_buf(5'd0, 11'd8, ALIGN_4, 1'b1, 1'b1, b);
         finish_pkt(16'hBEEF, e[0]);
         cmp_flag(irq, 1'b0);
      end
      $display("test interrupt done");
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
